/* verilog/fdfm_consts.svh */
// Constants of the finisher drive fault monitor: codes, fields, timing.
// Overview of operation
// R1 - Lift started with lower limit ON: fault if limit not OFF in time.
// R2 - Lift started: fault if neither paper surface sensor turns ON in time.
// R3 - Lowering started: fault if lower limit sensor not ON in time.
// R4 - Fan commanded on: fault if lock input stays low for the period.
// R5 - Timers restart on motor start, cancel on transition; periods constant.
`ifndef FDFM_CONSTS_SVH
`define FDFM_CONSTS_SVH

// Trouble codes shown while a fault is latched.
`define FDFM_CODE_NONE      16'h0000
`define FDFM_CODE_ELEVATE   16'h0ba0
`define FDFM_CODE_FAN       16'h0be1

// Bit positions of the fault cause vector.
`define FDFM_CAUSE_LIMIT_OFF 0
`define FDFM_CAUSE_SURFACE   1
`define FDFM_CAUSE_LIMIT_ON  2
`define FDFM_CAUSE_FAN_LOCK  3
`define FDFM_CAUSE_RESET     4'h0

// Clock rate and supervision periods.
`define FDFM_CLK_FREQ_HZ     200000000
`define FDFM_ELEV_PERIOD_MS  5000
`define FDFM_FAN_PERIOD_MS   3000
`define FDFM_ELEV_PERIOD_CYC (`FDFM_ELEV_PERIOD_MS * (`FDFM_CLK_FREQ_HZ / 1000))
`define FDFM_FAN_PERIOD_CYC  (`FDFM_FAN_PERIOD_MS * (`FDFM_CLK_FREQ_HZ / 1000))

`endif

/* verilog/fdfm_pkg.sv */
// Types shared by the finisher drive fault monitor.
package fdfm_pkg;

   typedef logic [15:0] fdfm_code_t;
   typedef logic [3:0]  fdfm_cause_t;
   typedef logic [31:0] fdfm_count_t;

   // Gray coded along idle -> lift -> lower.
   typedef enum logic [1:0] {
      FDFM_TRAY_IDLE  = 2'b00,
      FDFM_TRAY_LIFT  = 2'b01,
      FDFM_TRAY_LOWER = 2'b11
   } fdfm_tray_state_t;

endpackage : fdfm_pkg

/* verilog/fdfm_timer.sv */
// One supervision timer: armed by a start, cancelled by the awaited event.
`timescale 1ns/1ps
module fdfm_timer (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                start,
   input  wire logic                run,
   input  wire logic                cancel,
   input  wire fdfm_pkg::fdfm_count_t limit,
   output logic                     expired
);
   import fdfm_pkg::*;

   logic        armed;
   fdfm_count_t count;
   logic        at_limit;

   // A limit of zero behaves as one cycle.
   assign at_limit = ({1'b0, count} + 33'h1) >= {1'b0, limit};

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         armed <= 1'b0;
      end else if (start) begin
         armed <= 1'b1; // R5
      end else if (cancel || !run) begin
         armed <= 1'b0; // R5
      end else if (armed && at_limit) begin
         armed <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count <= 32'h0;
      end else if (start) begin
         count <= 32'h0; // R5
      end else if (armed && run && !cancel && !at_limit) begin
         count <= count + 32'h1;
      end
   end

   // The awaited event arriving on the deadline cycle still counts as met.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         expired <= 1'b0;
      end else begin
         expired <= !start && armed && run && !cancel && at_limit;
      end
   end

endmodule : fdfm_timer

/* verilog/fdfm_top.sv */
// Supervision of the exit tray elevate drive and the cooling fan.
`timescale 1ns/1ps
`include "fdfm_consts.svh"
module fdfm_top #(
   parameter int unsigned ELEV_LIMIT_CYC = `FDFM_ELEV_PERIOD_CYC,
   parameter int unsigned FAN_LIMIT_CYC  = `FDFM_FAN_PERIOD_CYC
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic                 tray_elevate_motor_up,
   input  wire logic                 tray_elevate_motor_down,
   input  wire logic                 tray_lower_limit_sensor,
   input  wire logic                 paper_surface_sensor_a,
   input  wire logic                 paper_surface_sensor_b,
   input  wire logic                 cooling_fan_motor_on,
   input  wire logic                 fan_lock,
   input  wire logic                 fault_clear,
   output logic                      elevate_drive_fault,
   output logic                      fan_drive_fault,
   output fdfm_pkg::fdfm_code_t      trouble_code,
   output fdfm_pkg::fdfm_cause_t     fault_cause,
   output logic                      fault_event,
   output logic                      elevate_drive_inhibit
);
   import fdfm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Tray direction tracking.

   fdfm_tray_state_t tray_state;
   fdfm_tray_state_t next_tray_state;
   logic             lift_start;
   logic             lower_start;
   logic             lifting;
   logic             lowering;
   logic             fan_low_run;
   logic             fan_low_prev;
   logic             fan_start;

   // Both directions commanded at once is not a drive state; treat it as
   // stopped so that no timer runs on a contradictory command.
   always_comb begin
      next_tray_state = FDFM_TRAY_IDLE;
      if (tray_elevate_motor_up && !tray_elevate_motor_down) begin
         next_tray_state = FDFM_TRAY_LIFT;
      end else if (tray_elevate_motor_down && !tray_elevate_motor_up) begin
         next_tray_state = FDFM_TRAY_LOWER;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tray_state <= FDFM_TRAY_IDLE;
      end else begin
         tray_state <= next_tray_state;
      end
   end

   // A direction reversal is a fresh start in the new direction.
   always_comb begin
      lift_start  = 1'b0;
      lower_start = 1'b0;
      unique case (tray_state)
         FDFM_TRAY_IDLE: begin
            lift_start  = next_tray_state == FDFM_TRAY_LIFT;
            lower_start = next_tray_state == FDFM_TRAY_LOWER;
         end
         FDFM_TRAY_LIFT: begin
            lower_start = next_tray_state == FDFM_TRAY_LOWER;
         end
         FDFM_TRAY_LOWER: begin
            lift_start  = next_tray_state == FDFM_TRAY_LIFT;
         end
         default: begin
            lift_start  = 1'b0;
            lower_start = 1'b0;
         end
      endcase
   end

   assign lifting  = next_tray_state == FDFM_TRAY_LIFT;
   assign lowering = next_tray_state == FDFM_TRAY_LOWER;

   ////////////////////////////////////////////////////////////////////////
   // Fan lock low detection.

   assign fan_low_run = cooling_fan_motor_on && !fan_lock;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fan_low_prev <= 1'b0;
      end else begin
         fan_low_prev <= fan_low_run;
      end
   end

   // Each new low stretch restarts the count, so only a continuous low
   // stretch can reach the period.
   assign fan_start = fan_low_run && !fan_low_prev; // R4

   ////////////////////////////////////////////////////////////////////////
   // Supervision timers.

   logic exp_limit_off;
   logic exp_surface;
   logic exp_limit_on;
   logic exp_fan;

   fdfm_timer u_limit_off (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (lift_start && tray_lower_limit_sensor), // R1
      .run      (lifting),
      .cancel   (!tray_lower_limit_sensor), // R1
      .limit    (fdfm_count_t'(ELEV_LIMIT_CYC)),
      .expired  (exp_limit_off)
   );

   fdfm_timer u_surface (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (lift_start), // R2
      .run      (lifting),
      .cancel   (paper_surface_sensor_a || paper_surface_sensor_b), // R2
      .limit    (fdfm_count_t'(ELEV_LIMIT_CYC)),
      .expired  (exp_surface)
   );

   fdfm_timer u_limit_on (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (lower_start), // R3
      .run      (lowering),
      .cancel   (tray_lower_limit_sensor), // R3
      .limit    (fdfm_count_t'(ELEV_LIMIT_CYC)),
      .expired  (exp_limit_on)
   );

   fdfm_timer u_fan (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (fan_start), // R4
      .run      (fan_low_run),
      .cancel   (1'b0),
      .limit    (fdfm_count_t'(FAN_LIMIT_CYC)),
      .expired  (exp_fan)
   );

   ////////////////////////////////////////////////////////////////////////
   // Latched faults and a one-cycle fault event. A detection in the clear cycle survives the clear.

   logic        elev_set;
   fdfm_cause_t cause_set;
   assign elev_set = exp_limit_off || exp_surface || exp_limit_on;

   always_comb begin
      cause_set                        = `FDFM_CAUSE_RESET;
      cause_set[`FDFM_CAUSE_LIMIT_OFF] = exp_limit_off;
      cause_set[`FDFM_CAUSE_SURFACE]   = exp_surface;
      cause_set[`FDFM_CAUSE_LIMIT_ON]  = exp_limit_on;
      cause_set[`FDFM_CAUSE_FAN_LOCK]  = exp_fan;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         elevate_drive_fault <= 1'b0;
      end else if (elev_set) begin
         elevate_drive_fault <= 1'b1; // R1 R2 R3
      end else if (fault_clear) begin
         elevate_drive_fault <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fan_drive_fault <= 1'b0;
      end else if (exp_fan) begin
         fan_drive_fault <= 1'b1; // R4
      end else if (fault_clear) begin
         fan_drive_fault <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fault_cause <= `FDFM_CAUSE_RESET;
      end else begin
         fault_cause <= (fault_clear ? `FDFM_CAUSE_RESET : fault_cause)
                        | cause_set;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fault_event <= 1'b0;
      end else begin
         fault_event <= elev_set || exp_fan;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reported code, one cycle behind the fault flags; drive inhibit, rising with the elevate fault and falling one cycle after it.

   // The elevate drive fault takes precedence when both are latched, as a
   // stalled tray is the more urgent mechanical hazard.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         trouble_code <= `FDFM_CODE_NONE;
      end else if (elevate_drive_fault) begin
         trouble_code <= `FDFM_CODE_ELEVATE;
      end else if (fan_drive_fault) begin
         trouble_code <= `FDFM_CODE_FAN;
      end else begin
         trouble_code <= `FDFM_CODE_NONE;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         elevate_drive_inhibit <= 1'b0;
      end else begin
         elevate_drive_inhibit <= elev_set || elevate_drive_fault;
      end
   end

endmodule : fdfm_top

/* testbench/fdfm_plant.sv */
// Behavioural exit tray, position sensors and cooling fan at the far side.
`timescale 1ns/1ps
module fdfm_plant #(
   parameter int TOP = 4
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic up,
   input  wire logic down,
   input  wire logic fan_on,
   input  wire logic stuck,
   input  wire logic b_only,
   output logic      limit,
   output logic      surf_a,
   output logic      surf_b,
   output logic      lock
);
   int pos;
   int spin;
   // A jammed drive leaves the tray where it was and the fan locked.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pos <= 0;
         spin <= 0;
      end else if (!stuck) begin
         if (up && !down && pos < TOP) pos <= pos + 1;
         if (down && !up && pos > 0) pos <= pos - 1;
         spin <= fan_on ? spin + 1 : 0;
      end else spin <= 0;
   end
   assign limit  = (pos == 0);
   assign surf_a = (pos == TOP) && !b_only;
   assign surf_b = (pos == TOP) && b_only;
   assign lock   = (spin >= 2);
endmodule : fdfm_plant

/* testbench/fdfm_top_props.sv */
// Concurrent checks of the drive fault monitor outputs.
`timescale 1ns/1ps
`include "fdfm_consts.svh"
module fdfm_top_props #(
   parameter int unsigned ELEV_LIMIT_CYC = 8,
   parameter int unsigned FAN_LIMIT_CYC  = 8
) (
   input wire logic                  core_clk,
   input wire logic                  rst,
   input wire logic                  tray_elevate_motor_up,
   input wire logic                  tray_elevate_motor_down,
   input wire logic                  tray_lower_limit_sensor,
   input wire logic                  paper_surface_sensor_a,
   input wire logic                  paper_surface_sensor_b,
   input wire logic                  cooling_fan_motor_on,
   input wire logic                  fan_lock,
   input wire logic                  fault_clear,
   input wire logic                  elevate_drive_fault,
   input wire logic                  fan_drive_fault,
   input wire fdfm_pkg::fdfm_code_t  trouble_code,
   input wire fdfm_pkg::fdfm_cause_t fault_cause,
   input wire logic                  fault_event,
   input wire logic                  elevate_drive_inhibit
);
   logic lift;
   logic lower;
   int   fan_cnt;
   int   surf_cnt;
   int   low_cnt;
   assign lift  = tray_elevate_motor_up && !tray_elevate_motor_down;
   assign lower = tray_elevate_motor_down && !tray_elevate_motor_up;
   // Cycles for which each awaited transition has been missing.
   always_ff @(posedge core_clk or posedge rst)
      if (rst) fan_cnt <= 0;
      else fan_cnt <= (cooling_fan_motor_on && !fan_lock) ? fan_cnt + 1 : 0;
   always_ff @(posedge core_clk or posedge rst)
      if (rst) surf_cnt <= 0;
      else surf_cnt <= (lift && !paper_surface_sensor_a
                        && !paper_surface_sensor_b) ? surf_cnt + 1 : 0;
   always_ff @(posedge core_clk or posedge rst)
      if (rst) low_cnt <= 0;
      else low_cnt <= (lower && !tray_lower_limit_sensor) ? low_cnt + 1 : 0;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_code_follows: assert property (trouble_code == (
      $past(elevate_drive_fault) ? `FDFM_CODE_ELEVATE : $past(fan_drive_fault)
      ? `FDFM_CODE_FAN : `FDFM_CODE_NONE)) else $error("code lags wrongly");
   a_event_on_set: assert property ($rose(elevate_drive_fault)
      || $rose(fan_drive_fault) |-> fault_event) else $error("no event");
   a_inhibit_tracks: assert property ($rose(elevate_drive_fault)
      |-> elevate_drive_inhibit ##1 elevate_drive_inhibit)
      else $error("inhibit missing");
   a_fault_sticky: assert property ($fell(elevate_drive_fault)
      |-> $past(fault_clear)) else $error("fault dropped without clear");
   a_fan_exact: assert property ($rose(fan_drive_fault)
      |-> fan_cnt == FAN_LIMIT_CYC + 2) else $error("fan fault timing");
   a_fan_late: assert property (fan_cnt == FAN_LIMIT_CYC + 2
      |-> fan_drive_fault) else $error("fan fault missing");
   a_surf_exact: assert property ($rose(fault_cause[1])
      |-> surf_cnt == ELEV_LIMIT_CYC + 2) else $error("surface timing");
   a_lower_exact: assert property ($rose(fault_cause[2])
      |-> low_cnt == ELEV_LIMIT_CYC + 2) else $error("lower timing");
   cover property ($rose(fan_drive_fault));
   cover property ($rose(fault_cause[1]));
   cover property ($rose(fault_cause[2]));
   cover property (elevate_drive_fault && fan_drive_fault);
endmodule : fdfm_top_props
bind fdfm_top fdfm_top_props #(.ELEV_LIMIT_CYC(ELEV_LIMIT_CYC),
   .FAN_LIMIT_CYC(FAN_LIMIT_CYC)) u_props (.core_clk(core_clk), .rst(rst),
   .tray_elevate_motor_up(tray_elevate_motor_up),
   .tray_elevate_motor_down(tray_elevate_motor_down),
   .tray_lower_limit_sensor(tray_lower_limit_sensor),
   .paper_surface_sensor_a(paper_surface_sensor_a),
   .paper_surface_sensor_b(paper_surface_sensor_b),
   .cooling_fan_motor_on(cooling_fan_motor_on), .fan_lock(fan_lock),
   .fault_clear(fault_clear), .elevate_drive_fault(elevate_drive_fault),
   .fan_drive_fault(fan_drive_fault), .trouble_code(trouble_code),
   .fault_cause(fault_cause), .fault_event(fault_event),
   .elevate_drive_inhibit(elevate_drive_inhibit));

/* testbench/fdfm_top_bench.sv */
// Self-checking bench of the drive fault monitor with a tray and fan model.
`timescale 1ns/1ps
module fdfm_top_bench;
   import fdfm_pkg::*;
   localparam int EN = 8;
   localparam int FN = 6;
   logic core_clk = 0, rst = 1, up = 0, down = 0, fan_on = 0, stuck = 0;
   logic clr = 0, b_only = 0, limit, sa, sb, lock, ef, ff, ev, inh;
   fdfm_code_t  code;
   fdfm_cause_t cause;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n;
   always #2.5 core_clk = ~core_clk;
   fdfm_top #(.ELEV_LIMIT_CYC(EN), .FAN_LIMIT_CYC(FN)) dut (
      .core_clk(core_clk), .rst(rst), .tray_elevate_motor_up(up),
      .tray_elevate_motor_down(down), .tray_lower_limit_sensor(limit),
      .paper_surface_sensor_a(sa), .paper_surface_sensor_b(sb),
      .cooling_fan_motor_on(fan_on), .fan_lock(lock), .fault_clear(clr),
      .elevate_drive_fault(ef), .fan_drive_fault(ff), .trouble_code(code),
      .fault_cause(cause), .fault_event(ev), .elevate_drive_inhibit(inh));
   fdfm_plant plant (.core_clk(core_clk), .rst(rst), .up(up), .down(down),
      .fan_on(fan_on), .stuck(stuck), .b_only(b_only), .limit(limit),
      .surf_a(sa),
      .surf_b(sb), .lock(lock));
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : tick
   // Cycles from the command until the fault flag of the chosen path rises.
   task automatic wait_fault(input bit fan);
      n = 0;
      do begin
         tick(1);
         n++;
      end while (!(fan ? ff : ef) && n < 60);
   endtask : wait_fault
   task automatic stop_clear();
      {up, down, fan_on, stuck, clr} = 5'h01;
      tick(1);
      clr = 0;
      chk("flags", 16'h0000, {ef, ff, cause});
      tick(1);
      chk("code", 16'h0000, {code[15:1], inh});
   endtask : stop_clear
   task automatic t_normal();
      up = 1;
      tick(EN + 4);
      chk("lift ok", 16'h0000, {ef, cause});
      {up, down} = 2'b01;
      tick(EN + 4);
      chk("lower ok", 16'h0000, {ef, cause});
      {down, fan_on} = 2'b01;
      tick(FN + 4);
      chk("fan ok", 16'h0000, {ff, cause});
      stop_clear();
   endtask : t_normal
   task automatic t_lift_stuck();
      {stuck, up} = 2'b11;
      wait_fault(0);
      chk("lift cycles", EN + 2, n);
      chk("lift flags", 16'h00d3, {inh, ev, ff, ef, cause});
      tick(1);
      chk("lift code", 16'h0ba0, code);
      chk("event pulse", 16'h0000, ev);
      stop_clear();
   endtask : t_lift_stuck
   task automatic t_lower_stuck();
      {up, b_only} = 2'b11;
      tick(EN + 4);
      chk("lift by b", 16'h0000, {ef, cause});
      {stuck, up, down, b_only} = 4'b1010;
      wait_fault(0);
      chk("lower cycles", EN + 2, n);
      chk("lower cause", 16'h0004, cause);
      stop_clear();
   endtask : t_lower_stuck
   task automatic t_fan_stuck();
      {stuck, fan_on} = 2'b11;
      wait_fault(1);
      chk("fan cycles", FN + 2, n);
      chk("fan flags", 16'h0028, {ff, ef, cause});
      tick(1);
      chk("fan code", 16'h0be1, code);
      stop_clear();
   endtask : t_fan_stuck
   // Tray stalled while lowering and fan locked: elevate code wins.
   task automatic t_both();
      {stuck, down, fan_on} = 3'b111;
      wait_fault(0);
      chk("both flags", 16'h003c, {ff, ef, cause});
      tick(1);
      chk("both code", 16'h0ba0, code);
      stop_clear();
   endtask : t_both
   // A clear on the detection edge loses; then a reset in mid-run.
   task automatic t_clear_race();
      {stuck, fan_on} = 2'b11;
      tick(FN + 1);
      clr = 1;
      tick(1);
      clr = 0;
      chk("clear race", 16'h0018, {ff, cause});
      {rst, stuck, fan_on} = 3'b100;
      tick(2);
      rst = 0;
      tick(1);
      chk("reset flags", 16'h0000, {ff, ef, ev, inh, cause});
      chk("reset code", 16'h0000, code);
   endtask : t_clear_race
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // The whole run needs about 130 cycles; a hang ends here.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 1000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      tick(20);
      rst = 0;
      tick(1);
      t_normal();
      t_lift_stuck();
      t_lower_stuck();
      t_fan_stuck();
      t_both();
      t_clear_race();
      report_and_stop();
   end
endmodule : fdfm_top_bench
